// file: hw/bfr_defines.svh
// Offsets, field positions, reset values and timing counts for the
// bus fault response selector. Definitions only; included by bare name.
`ifndef BFR_DEFINES_SVH
`define BFR_DEFINES_SVH

// ==========================================================
// Register command codes
`define BFR_GLOBAL_CTRL_ADDR 8'hB0
`define BFR_LOW_RESP_ADDR 8'hB1
`define BFR_HIGH_RESP_ADDR 8'hB2
`define BFR_FAULT_STATUS_ADDR 8'hD2

// ==========================================================
// Field positions
`define BFR_IND_EN_BIT 7
`define BFR_LOW_IN_UV_HI 7
`define BFR_LOW_IN_UV_LO 6
`define BFR_HIGH_OUT_OV_HI 1
`define BFR_HIGH_OUT_OV_LO 0
`define BFR_ST_LOW_IN_UV 3
`define BFR_ST_HIGH_OUT_OV 4

// ==========================================================
// Reset values and unmapped read data
`define BFR_GLOBAL_CTRL_RST 8'h00
`define BFR_LOW_RESP_RST 8'h00
`define BFR_HIGH_RESP_RST 8'h00
`define BFR_FAULT_STATUS_RST 8'h00
`define BFR_UNMAPPED_DATA 8'h00

// ==========================================================
// Hiccup restart delay
`define BFR_CLK_PERIOD_NS 10
`define BFR_HICCUP_MS 500
`define BFR_HICCUP_CYCLES ((`BFR_HICCUP_MS * 1000000) / `BFR_CLK_PERIOD_NS)
`define BFR_HICCUP_W 26

`endif

// file: hw/bfr_pkg.sv
// Types shared by the fault response selector and its channels.
// Assumes nothing beyond a SystemVerilog compiler.
package bfr_pkg;

	// ==========================================================
	// Response codes of a 2-bit field
	typedef enum logic [1:0] {
		BFR_RESP_FLAG = 2'h0,
		BFR_RESP_HICCUP = 2'h1,
		BFR_RESP_LATCH = 2'h2,
		BFR_RESP_FLAG_ALT = 2'h3
	} bfr_resp_t;

	// ==========================================================
	// Per-fault channel states
	typedef enum logic [2:0] {
		BFR_CH_IDLE = 3'b000,
		BFR_CH_FLAG = 3'b001,
		BFR_CH_HOLD = 3'b010,
		BFR_CH_WAIT = 3'b011,
		BFR_CH_LATCH = 3'b100
	} bfr_ch_state_t;

endpackage

// file: hw/bfr_fault_chan.sv
// One fault channel: turns a fault level and a response code into a
// stop request. Assumes fault and release are synchronous to mclk.
`timescale 1ns/1ns
`include "bfr_defines.svh"

module bfr_fault_chan
	import bfr_pkg::*;
#(
	parameter int HICCUP_CYCLES = `BFR_HICCUP_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic fault,
	input wire logic [1:0] resp,
	input wire logic release_req,
	output logic stop
);

	localparam logic [`BFR_HICCUP_W-1:0] LAST =
		`BFR_HICCUP_W'(HICCUP_CYCLES - 1);

	bfr_ch_state_t state;
	logic [`BFR_HICCUP_W-1:0] cnt;

	// ==========================================================
	// Response sequencing; code taken at the onset of a fault
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= BFR_CH_IDLE;
		end else begin
			case (state)
				BFR_CH_IDLE: begin
					if (fault) begin
						case (resp)
							BFR_RESP_HICCUP: state <= BFR_CH_HOLD; // see R4
							BFR_RESP_LATCH: state <= BFR_CH_LATCH; // see R5
							default: state <= BFR_CH_FLAG; // see R6
						endcase
					end
				end
				BFR_CH_FLAG: if (!fault) state <= BFR_CH_IDLE;
				BFR_CH_HOLD: if (!fault) state <= BFR_CH_WAIT;
				BFR_CH_WAIT: begin
					// A returning fault restarts the whole hiccup
					if (fault) state <= BFR_CH_HOLD;
					else if (cnt == LAST) state <= BFR_CH_IDLE; // see R4
				end
				BFR_CH_LATCH: if (release_req) state <= BFR_CH_IDLE; // see R5
				default: state <= BFR_CH_IDLE;
			endcase
		end
	end

	// Restart delay counter, runs only while waiting
	always_ff @(posedge mclk) begin
		if (srst || state != BFR_CH_WAIT) cnt <= '0;
		else cnt <= cnt + `BFR_HICCUP_W'(1);
	end

	assign stop = (state == BFR_CH_HOLD) || (state == BFR_CH_WAIT) ||
		(state == BFR_CH_LATCH);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	flag_code_map_a: assert property ( // see R6
		$rose(fault) && $past(state) == BFR_CH_IDLE &&
		(resp == 2'h0 || resp == 2'h3) |=> state == BFR_CH_FLAG)
		else $error("flag-only code did not give flag state");
	hiccup_done_a: assert property ( // see R4
		state == BFR_CH_WAIT && !fault && cnt == LAST
		|=> state == BFR_CH_IDLE && !stop)
		else $error("hiccup did not end after the delay");
	latch_hold_a: assert property ( // see R5
		state == BFR_CH_LATCH && !release_req |=> stop)
		else $error("latch-off released without enable toggle");
	hiccup_cov_c: cover property (state == BFR_CH_WAIT && cnt == LAST);

endmodule // bfr_fault_chan

// file: hw/bfr_top.sv
// Fault response selector: response registers, status flags and the
// switching gate. Assumes a management-bus front end that presents
// one-cycle byte commands, and fault levels synchronous to mclk.
//
// What this block does
// R1 - Global enable set: each fault uses its own 2-bit response field.
// R2 - Global enable clear: mode pin response used, fields ignored.
// R3 - Low bus input undervoltage, code 00: set status bit 3, pin low, run.
// R4 - Low bus undervoltage, code 01: stop, restart 500 ms after clearing.
// R5 - Low bus undervoltage, code 10: stop until an enable input toggles.
// R6 - Code 11 in any field behaves as code 00, flag only.
// R7 - High bus output overvoltage uses bits 1:0 of second response register.
// R8 - High bus overvoltage, code 00: set status bit 4, pin low, run.
// R9 - High bus overvoltage, code 01: stop, restart 500 ms after clearing.
// R10 - High bus overvoltage, code 10: stop until an enable input toggles.
// R11 - Second response register: byte, read/write, protectable, resets zero.
// R12 - Second register fields: in UV 7:6, in OV 5:4, out UV 3:2, out OV 1:0.
// R13 - Status pin low while any status bit set, high once all cleared.
`timescale 1ns/1ns
`include "bfr_defines.svh"

module bfr_top
	import bfr_pkg::*;
#(
	parameter int HICCUP_CYCLES = `BFR_HICCUP_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_wdata,
	input wire logic write_protect,
	input wire logic [1:0] mode_resp,
	input wire logic pwm_en,
	input wire logic chip_en,
	input wire logic low_voltage_bus_in_uv,
	input wire logic high_voltage_bus_out_ov,
	output logic [7:0] cmd_rdata,
	output logic cmd_rack,
	output logic switching_on,
	output logic fault_status_out_n
);

	// ==========================================================
	// Register storage
	logic [7:0] global_ctrl;
	logic [7:0] low_bus_fault_response_ctrl;
	logic [7:0] high_bus_fault_response_ctrl;
	logic [7:0] fault_status;
	logic [7:0] next_fault_status;
	logic [7:0] status_set;
	logic ind_en;
	logic cfg_wr_ok;
	logic [1:0] low_uv_code;
	logic [1:0] high_ov_code;
	logic low_uv_stop;
	logic high_ov_stop;
	logic release_req;

	// Protection covers the configuration bytes, never the status clear
	assign cfg_wr_ok = cmd_wr && !write_protect; // see R11

	// Global control byte; only the enable bit is held
	always_ff @(posedge mclk) begin
		if (srst) begin
			global_ctrl <= `BFR_GLOBAL_CTRL_RST;
		end else if (cfg_wr_ok && cmd_code == `BFR_GLOBAL_CTRL_ADDR) begin
			global_ctrl <= cmd_wdata & 8'h80;
		end
	end

	// Low bus response byte, all fields stored
	always_ff @(posedge mclk) begin
		if (srst) begin
			low_bus_fault_response_ctrl <= `BFR_LOW_RESP_RST;
		end else if (cfg_wr_ok && cmd_code == `BFR_LOW_RESP_ADDR) begin
			low_bus_fault_response_ctrl <= cmd_wdata;
		end
	end

	// High bus response byte, four 2-bit fields
	always_ff @(posedge mclk) begin
		if (srst) begin
			high_bus_fault_response_ctrl <= `BFR_HIGH_RESP_RST; // see R11
		end else if (cfg_wr_ok && cmd_code == `BFR_HIGH_RESP_ADDR) begin
			high_bus_fault_response_ctrl <= cmd_wdata; // see R12
		end
	end

	// ==========================================================
	// Response selection
	assign ind_en = global_ctrl[`BFR_IND_EN_BIT];

	// Field when enabled, else the mode pin; 11 folded in the channel
	assign low_uv_code = ind_en ? // see R1
		low_bus_fault_response_ctrl[`BFR_LOW_IN_UV_HI:`BFR_LOW_IN_UV_LO] :
		mode_resp; // see R2
	assign high_ov_code = ind_en ? // see R7
		high_bus_fault_response_ctrl[`BFR_HIGH_OUT_OV_HI:
			`BFR_HIGH_OUT_OV_LO] :
		mode_resp; // see R2

	// Either enable low counts as the toggle that frees a latch-off
	assign release_req = !pwm_en || !chip_en; // see R5 R10

	// ==========================================================
	// Fault channels
	// One channel per fault; both share the enable release
	bfr_fault_chan #(
		.HICCUP_CYCLES(HICCUP_CYCLES)
	) low_uv_chan (
		.mclk(mclk),
		.srst(srst),
		.fault(low_voltage_bus_in_uv),
		.resp(low_uv_code),
		.release_req(release_req),
		.stop(low_uv_stop)
	);

	bfr_fault_chan #(
		.HICCUP_CYCLES(HICCUP_CYCLES)
	) high_ov_chan (
		.mclk(mclk),
		.srst(srst),
		.fault(high_voltage_bus_out_ov),
		.resp(high_ov_code),
		.release_req(release_req),
		.stop(high_ov_stop)
	);

	// ==========================================================
	// Fault status, write one to clear
	// Only bits 3 and 4 have a source; the rest stay zero
	always_comb begin
		status_set = 8'h00;
		status_set[`BFR_ST_LOW_IN_UV] = low_voltage_bus_in_uv; // see R3
		status_set[`BFR_ST_HIGH_OUT_OV] = high_voltage_bus_out_ov; // see R8
		next_fault_status = fault_status;
		if (cmd_wr && cmd_code == `BFR_FAULT_STATUS_ADDR) begin
			next_fault_status = fault_status & ~cmd_wdata;
		end
		// A fault in the clearing cycle must survive the clear
		next_fault_status = next_fault_status | status_set;
	end

	always_ff @(posedge mclk) begin
		if (srst) fault_status <= `BFR_FAULT_STATUS_RST;
		else fault_status <= next_fault_status;
	end

	// Status pin follows the stored flags, not the raw fault
	always_ff @(posedge mclk) begin
		if (srst) fault_status_out_n <= 1'b1;
		else fault_status_out_n <= ~|fault_status; // see R13
	end

	// ==========================================================
	// Switching gate; flag-only channels never stop it
	always_ff @(posedge mclk) begin
		if (srst) begin
			switching_on <= 1'b0;
		end else begin
			switching_on <= pwm_en && chip_en && // see R3 R8
				!low_uv_stop && !high_ov_stop; // see R4 R9 R10
		end
	end

	// ==========================================================
	// Register read port, answer one cycle after the request
	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_rdata <= 8'h00;
			cmd_rack <= 1'b0;
		end else begin
			cmd_rack <= cmd_rd;
			if (cmd_rd) begin
				case (cmd_code)
					`BFR_GLOBAL_CTRL_ADDR: cmd_rdata <= global_ctrl;
					`BFR_LOW_RESP_ADDR:
						cmd_rdata <= low_bus_fault_response_ctrl;
					`BFR_HIGH_RESP_ADDR:
						cmd_rdata <= high_bus_fault_response_ctrl;
					`BFR_FAULT_STATUS_ADDR: cmd_rdata <= fault_status;
					default: cmd_rdata <= `BFR_UNMAPPED_DATA;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	field_latch_stop_a: assert property ( // see R1
		$rose(low_voltage_bus_in_uv) && ind_en &&
		low_bus_fault_response_ctrl[7:6] == 2'h2 |-> ##2 !switching_on)
		else $error("low bus latch-off field did not stop switching");

	mode_pin_use_a: assert property ( // see R2
		$rose(high_voltage_bus_out_ov) && !ind_en && mode_resp == 2'h1
		|-> ##2 !switching_on)
		else $error("mode pin hiccup did not stop switching");

	low_uv_flag_a: assert property ( // see R3
		low_voltage_bus_in_uv |=> fault_status[3] ##1 !fault_status_out_n)
		else $error("low bus undervoltage not flagged");

	high_ov_flag_a: assert property ( // see R8
		high_voltage_bus_out_ov |=> fault_status[4] ##1 !fault_status_out_n)
		else $error("high bus overvoltage not flagged");

	ov_field_use_a: assert property ( // see R7
		$rose(high_voltage_bus_out_ov) && ind_en &&
		high_bus_fault_response_ctrl[1:0] == 2'h2 |-> ##2 !switching_on)
		else $error("high bus latch-off field did not stop switching");

	hiccup_wait_a: assert property ( // see R9
		$fell(high_voltage_bus_out_ov) && high_ov_stop
		|=> !switching_on [*8])
		else $error("hiccup restarted too early");

	latch_stay_a: assert property ( // see R10
		high_ov_stop && !low_uv_stop && pwm_en && chip_en &&
		!$past(release_req) && !$past(high_ov_stop)
		|-> ##1 !switching_on)
		else $error("latched fault let switching run");

	flag_only_run_a: assert property ( // see R6
		ind_en && pwm_en && chip_en && !low_uv_stop &&
		low_bus_fault_response_ctrl[7:6] == 2'h3 &&
		!high_voltage_bus_out_ov && !high_ov_stop
		|=> ##1 !$past(pwm_en && chip_en) || switching_on)
		else $error("flag-only code stopped switching");

	status_pin_a: assert property ( // see R13
		1'b1 |=> fault_status_out_n == !$past(|fault_status))
		else $error("status pin does not follow status flags");

	protect_hold_a: assert property ( // see R11
		cmd_wr && write_protect |=> $stable(high_bus_fault_response_ctrl))
		else $error("protected register changed");

	reset_zero_a: assert property ( // see R11
		disable iff (1'b0)
		$past(srst) |-> high_bus_fault_response_ctrl == 8'h00)
		else $error("second response register not zero after reset");

	set_wins_a: assert property ( // see R3
		cmd_wr && cmd_code == `BFR_FAULT_STATUS_ADDR && cmd_wdata[3] &&
		low_voltage_bus_in_uv |=> fault_status[3])
		else $error("status clear beat a new fault");

	// ==========================================================
	// Register port, hiccup hold and release checks
	enable_bit_a: assert property ( // see R1
		cfg_wr_ok && cmd_code == `BFR_GLOBAL_CTRL_ADDR
		|=> ind_en == $past(cmd_wdata[7]) && global_ctrl[6:0] == 7'h00)
		else $error("global enable byte holds the wrong bits");

	field_write_a: assert property ( // see R12
		cfg_wr_ok && cmd_code == `BFR_HIGH_RESP_ADDR
		|=> high_bus_fault_response_ctrl == $past(cmd_wdata))
		else $error("second response register missed a write");

	read_answer_a: assert property ( // see R11
		cmd_rd && cmd_code == `BFR_HIGH_RESP_ADDR
		|=> cmd_rack && cmd_rdata == $past(high_bus_fault_response_ctrl))
		else $error("second response register read back wrong");

	rack_single_a: assert property ( // see R11
		!cmd_rd |=> !cmd_rack)
		else $error("read acknowledge without a read");

	low_hiccup_hold_a: assert property ( // see R4
		$fell(low_voltage_bus_in_uv) && low_uv_stop
		|=> !switching_on [*8])
		else $error("low bus hiccup restarted too early");

	// The enable toggle must free a latch once both enables are back
	low_latch_free_a: assert property ( // see R5
		low_uv_chan.state == BFR_CH_LATCH && release_req
		##1 pwm_en && chip_en && !high_ov_stop |=> switching_on)
		else $error("enable toggle did not free the low bus latch");

	high_latch_free_a: assert property ( // see R10
		high_ov_chan.state == BFR_CH_LATCH && release_req
		##1 pwm_en && chip_en && !low_uv_stop |=> switching_on)
		else $error("enable toggle did not free the high bus latch");

	// Pin must rise two cycles after the last set bit is cleared
	status_release_a: assert property ( // see R13
		cmd_wr && cmd_code == `BFR_FAULT_STATUS_ADDR &&
		(fault_status & ~cmd_wdata) == 8'h00 &&
		!low_voltage_bus_in_uv && !high_voltage_bus_out_ov
		|-> ##2 fault_status_out_n)
		else $error("status pin stayed low after the last clear");

	mode_latch_cov_c: cover property (
		!ind_en && mode_resp == 2'h2 && low_uv_stop);

	latch_cov_c: cover property (
		low_uv_stop ##1 release_req ##1 !low_uv_stop);
	clear_cov_c: cover property (
		!fault_status_out_n ##1 cmd_wr ##2 fault_status_out_n);
	flag_run_cov_c: cover property (
		high_voltage_bus_out_ov && switching_on);

endmodule // bfr_top

// file: bench/bfr_ctl_model.sv
// System controller model: issues single-byte register commands.
// Assumes the block takes a strobe at the rising edge and answers a
// read with cmd_rack one cycle later.
`timescale 1ns/1ns

module bfr_ctl_model (
	input wire logic mclk,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_wdata,
	input wire logic [7:0] cmd_rdata,
	input wire logic cmd_rack
);
	// ==========================================================
	// Bus idle state
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 8'h00;
	end

	// One write pulse; released lines invert so stale data never matches
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(negedge mclk);
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge mclk);
		cmd_wr = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
	endtask

	// One read; a missing acknowledge returns unknowns to the caller
	// Strobe taken at the next rising edge; the answer stands one
	// cycle, so it is read at the following falling edge
	task automatic rd(input logic [7:0] c, output logic [7:0] d);
		@(negedge mclk);
		cmd_rd = 1'b1;
		cmd_code = c;
		@(negedge mclk);
		d = cmd_rack ? cmd_rdata : 8'hXX;
		cmd_rd = 1'b0;
		cmd_code = ~c;
	endtask
endmodule // bfr_ctl_model

// file: bench/tb_bfr_top.sv
// Testbench for the fault response selector.
// Assumes the controller model drives the register strobes.
`timescale 1ns/1ns
`include "bfr_defines.svh"

module tb_bfr_top;
	localparam int HC = 20;
	logic mclk = 1'b0, srst = 1'b1, write_protect = 1'b0;
	logic pwm_en = 1'b1, chip_en = 1'b1, low_uv = 1'b0, high_ov = 1'b0;
	logic [1:0] mode_resp = 2'h0;
	logic cmd_wr, cmd_rd, cmd_rack, switching_on, fault_status_out_n;
	logic [7:0] cmd_code, cmd_wdata, cmd_rdata, d;
	int error_cnt = 0, compares = 0;

	// ==========================================================
	// Clock, design and controller
	always #5 mclk = ~mclk;

	bfr_top #(.HICCUP_CYCLES(HC)) bfr_top_i (.mclk(mclk), .srst(srst),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .write_protect(write_protect),
		.mode_resp(mode_resp), .pwm_en(pwm_en), .chip_en(chip_en),
		.low_voltage_bus_in_uv(low_uv), .high_voltage_bus_out_ov(high_ov),
		.cmd_rdata(cmd_rdata), .cmd_rack(cmd_rack),
		.switching_on(switching_on),
		.fault_status_out_n(fault_status_out_n));

	bfr_ctl_model bfr_ctl_model_i (.mclk(mclk), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_rack(cmd_rack));

	// ==========================================================
	// Comparison and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One fault event with effective code eff; sel picks the high bus
	task automatic fault_run(input logic sel, input logic [1:0] eff);
		int n;
		logic [7:0] bitm;
		bitm = sel ? 8'h10 : 8'h08;
		@(negedge mclk);
		if (sel) high_ov = 1'b1; else low_uv = 1'b1;
		repeat (4) @(negedge mclk);
		check(fault_status_out_n, 8'h00);
		check(switching_on, (^eff) ? 8'h00 : 8'h01);
		bfr_ctl_model_i.rd(`BFR_FAULT_STATUS_ADDR, d);
		check(d & bitm, bitm);
		@(negedge mclk);
		if (sel) high_ov = 1'b0; else low_uv = 1'b0;
		n = 0;
		// Hiccup must hold off the whole restart delay, not just a while
		while (switching_on !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (eff == 2'h1)
			check(n >= HC && n <= HC + 5, 8'h01);
		if (eff == 2'h2) begin
			check(switching_on, 8'h00);
			@(negedge mclk);
			if (sel) chip_en = 1'b0; else pwm_en = 1'b0;
			@(negedge mclk);
			chip_en = 1'b1;
			pwm_en = 1'b1;
			repeat (4) @(negedge mclk);
			check(switching_on, 8'h01);
		end
		bfr_ctl_model_i.wr(`BFR_FAULT_STATUS_ADDR, bitm);
		repeat (3) @(negedge mclk);
		check(fault_status_out_n, 8'h01);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		bfr_ctl_model_i.rd(`BFR_HIGH_RESP_ADDR, d);
		check(d, 8'h00);
		check(fault_status_out_n, 8'h01);
		check(switching_on, 8'h01);
	endtask

	// Reset in mid-run returns the bytes to zero; bus usable at once
	task automatic t_mid_reset();
		@(negedge mclk);
		srst = 1'b1;
		repeat (2) @(negedge mclk);
		srst = 1'b0;
		bfr_ctl_model_i.rd(`BFR_HIGH_RESP_ADDR, d);
		check(d, 8'h00);
		bfr_ctl_model_i.rd(`BFR_GLOBAL_CTRL_ADDR, d);
		check(d, 8'h00);
		check(switching_on, 8'h01);
		check(fault_status_out_n, 8'h01);
	endtask

	// Clear during a live fault must lose; pin waits for the last bit
	task automatic t_status();
		@(negedge mclk);
		low_uv = 1'b1;
		high_ov = 1'b1;
		bfr_ctl_model_i.wr(`BFR_FAULT_STATUS_ADDR, 8'h18);
		bfr_ctl_model_i.rd(`BFR_FAULT_STATUS_ADDR, d);
		check(d, 8'h18);
		check(switching_on, 8'h01);
		@(negedge mclk);
		low_uv = 1'b0;
		high_ov = 1'b0;
		bfr_ctl_model_i.wr(`BFR_FAULT_STATUS_ADDR, 8'h08);
		repeat (3) @(negedge mclk);
		check(fault_status_out_n, 8'h00);
		bfr_ctl_model_i.wr(`BFR_FAULT_STATUS_ADDR, 8'h10);
		repeat (3) @(negedge mclk);
		check(fault_status_out_n, 8'h01);
		bfr_ctl_model_i.rd(`BFR_FAULT_STATUS_ADDR, d);
		check(d, 8'h00);
	endtask

	task automatic t_regs();
		bfr_ctl_model_i.wr(`BFR_HIGH_RESP_ADDR, 8'hA5);
		bfr_ctl_model_i.rd(`BFR_HIGH_RESP_ADDR, d);
		check(d, 8'hA5);
		write_protect = 1'b1;
		bfr_ctl_model_i.wr(`BFR_HIGH_RESP_ADDR, 8'h3C);
		bfr_ctl_model_i.rd(`BFR_HIGH_RESP_ADDR, d);
		check(d, 8'hA5);
		write_protect = 1'b0;
		bfr_ctl_model_i.rd(8'h55, d);
		check(d, `BFR_UNMAPPED_DATA);
		bfr_ctl_model_i.wr(`BFR_GLOBAL_CTRL_ADDR, 8'hFF);
		bfr_ctl_model_i.rd(`BFR_GLOBAL_CTRL_ADDR, d);
		check(d, 8'h80);
		bfr_ctl_model_i.wr(`BFR_LOW_RESP_ADDR, 8'h96);
		bfr_ctl_model_i.rd(`BFR_LOW_RESP_ADDR, d);
		check(d, 8'h96);
	endtask

	// Every code; neighbouring fields hold latch codes to expose misrouting
	task automatic t_fields();
		for (int c = 0; c < 4; c++) begin
			bfr_ctl_model_i.wr(`BFR_GLOBAL_CTRL_ADDR, 8'h80);
			bfr_ctl_model_i.wr(`BFR_LOW_RESP_ADDR, {c[1:0], 6'h2A});
			bfr_ctl_model_i.wr(`BFR_HIGH_RESP_ADDR, {6'h2A, c[1:0]});
			fault_run(1'b0, c[1:0]);
			fault_run(1'b1, c[1:0]);
		end
	endtask

	// Fields say latch; the mode pin must win while the enable is clear
	task automatic t_mode();
		bfr_ctl_model_i.wr(`BFR_GLOBAL_CTRL_ADDR, 8'h00);
		bfr_ctl_model_i.wr(`BFR_LOW_RESP_ADDR, 8'h80);
		bfr_ctl_model_i.wr(`BFR_HIGH_RESP_ADDR, 8'h02);
		for (int m = 0; m < 4; m++) begin
			@(negedge mclk);
			mode_resp = m[1:0];
			fault_run(m[0], m[1:0]);
		end
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (12) @(negedge mclk);
		srst = 1'b0;
		repeat (3) @(negedge mclk);
		t_reset();
		t_regs();
		t_mid_reset();
		t_fields();
		t_mode();
		t_status();
		tally_and_finish();
	end

	// Run needs well under 2000 cycles; this bound catches a hang
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish();
	end
endmodule // tb_bfr_top
